// File: core/usr_sync_port.sv
// Synchronous serial port with master and slave shift clock and AXI4-Lite registers.
//
// Operation
// R1: Either receive enable starts synchronous reception.
// R2: Sample data line on shift clock falling edge.
// R3: Master single receive takes one word, clears.
// R4: Continuous receive runs until cleared, overrides single.
// R5: Software clears both enables before starting.
// R6: Slave mode takes shift clock from remote party.
// R7: Sleep transmit queues two words, flag stays clear.
// R8: Transmit interrupt enable lets transmit wake core.
// R9: Slave mode ignores the single receive enable.
// R10: Slave receives during sleep, wakes on receive.
// R11: Port enable claims pins; clear resets machines.
// R12: Nine bit selects per direction choose frame length.
// R13: Address detect keeps only ninth-bit-set words.
// R14: Framing flag follows buffer reads and words.
// R15: Overrun clears only when continuous enable clears; the code also clears it when the port enable is clear.
// R16: Ninth received bit readable as status field.
// R17: Clock source select picks master or slave.
// R18: Mode select chooses synchronous or asynchronous operation; the code has no asynchronous mode, a clear mode select disables the port.
// R19: High baud select ignored in synchronous mode.
// R20: Transmit idle flag reads one when idle.
// R21: Receive enables take priority over transmit enable.
// R22: Ninth transmit bit comes from control field.
// R23: Receive buffer is a two entry FIFO.
// R24: Overrun blocks transfers and further reception.
// R25: Receive flag set on load, cleared when empty.
`timescale 1ns/1ps
module usr_sync_port #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address, data and response.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address and data.
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shift clock pin.
   input wire logic shift_clock_pin_sense,
   output logic shift_clock_pin_drive,
   output logic shift_clock_pin_oe,
   // Serial data pin.
   input wire logic serial_data_pin_sense,
   output logic serial_data_pin_drive,
   output logic serial_data_pin_oe,
   // Core sleep state and wake signalling.
   input wire logic sleep_mode,
   output logic receive_flag,
   output logic transmit_flag,
   output logic wake_request
);

   // Frame length for a nine bit select.
   function automatic logic [3:0] usr_bits(input logic nine);
      usr_bits = nine ? usr_pkg::BITS_9 : usr_pkg::BITS_8;
   endfunction

   // Maps a bus address onto a register selector.
   function automatic usr_pkg::usr_sel_t usr_dec(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = a[7:0];
      if (b == usr_pkg::ADDR_RCV_CTRL) begin
         usr_dec = usr_pkg::SEL_RCV;
      end else if (b == usr_pkg::ADDR_TX_CTRL) begin
         usr_dec = usr_pkg::SEL_TX;
      end else if (b == usr_pkg::ADDR_RX_BUF) begin
         usr_dec = usr_pkg::SEL_RXB;
      end else if (b == usr_pkg::ADDR_TX_BUF) begin
         usr_dec = usr_pkg::SEL_TXB;
      end else if (b == usr_pkg::ADDR_BAUD) begin
         usr_dec = usr_pkg::SEL_BAUD;
      end else if (b == usr_pkg::ADDR_IRQ_CTRL) begin
         usr_dec = usr_pkg::SEL_IRQ;
      end else begin
         usr_dec = usr_pkg::SEL_NONE;
      end
   endfunction

   // Register state.
   logic [7:0] rcv_r, rcv_nxt, txs_r, txs_nxt, baud_r, baud_nxt;
   logic [1:0] ien_r, ien_nxt;
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [ADDR_W-1:0] awa_r, awa_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic wstb_r, wstb_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   // Pin synchronisers and master clock.
   logic ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r;
   logic [7:0] div_r, div_nxt;
   logic mck_r, mck_nxt;
   // Receive path.
   usr_pkg::usr_rx_word_t mem_r [2];
   usr_pkg::usr_rx_word_t mem_nxt [2];
   logic wptr_r, wptr_nxt, rptr_r, rptr_nxt, overrun_error_flag_r, overrun_error_flag_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [8:0] rsr_r, rsr_nxt;
   logic [3:0] rbits_r, rbits_nxt;
   // Transmit path.
   usr_pkg::usr_tx_state_t tst_r, tst_nxt;
   logic [7:0] txb_r, txb_nxt;
   logic txb_full_r, txb_full_nxt, dt_r, dt_nxt, tx_wake_r, tx_wake_nxt;
   logic [8:0] tsr_r, tsr_nxt;
   logic [3:0] tbits_r, tbits_nxt;
   // Shared decode.
   logic en, master, rx_req, rx_on, tx_on, run_clk, tick;
   logic wr_en, continuous_receive_enable_clr, single_receive_enable_clr, txb_wr, pop;
   usr_pkg::usr_sel_t wsel;
   usr_pkg::usr_edge_t ev;
   usr_pkg::usr_rx_word_t head;

   // Operating mode and path arbitration.
   assign en = rcv_r[usr_pkg::RC_SERIAL_PORT_ENABLE] & txs_r[usr_pkg::TC_SYNC]; // [R11] [R18]
   assign master = txs_r[usr_pkg::TC_CLOCK_SOURCE_SELECT]; // [R17] [R6]
   assign rx_req = rcv_r[usr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE] | (master & rcv_r[usr_pkg::RC_SINGLE_RECEIVE_ENABLE]); // [R1] [R9]
   assign rx_on = en & rx_req & ~overrun_error_flag_r; // [R24]
   assign tx_on = en & txs_r[usr_pkg::TC_TRANSMIT_ENABLE_BIT] & ~rx_req; // [R21]
   assign run_clk = en & master & (rx_on | (tx_on & (tst_r == usr_pkg::TX_SHIFT)));
   assign tick = run_clk & (div_r == baud_r);
   assign head = mem_r[rptr_r];

   // Shift clock edges come from the divider as master or the pin as slave.
   always_comb begin
      if (master) begin
         ev.rise = tick & ~mck_r;
         ev.fall = tick & mck_r;
      end else begin
         ev.rise = ck_s2_r & ~ck_s3_r; // [R6]
         ev.fall = ~ck_s2_r & ck_s3_r;
      end
   end

   // Master clock divider; the high baud select plays no part here.
   always_comb begin
      div_nxt = 8'h00;
      mck_nxt = 1'b0;
      if (run_clk) begin
         div_nxt = tick ? 8'h00 : div_r + 8'h01; // [R19]
         mck_nxt = tick ? ~mck_r : mck_r;
      end
   end

   // Two flip-flop synchronisers on both pins, plus the divider state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         dt_s1_r <= 1'b0;
         dt_s2_r <= 1'b0;
         div_r <= 8'h00;
         mck_r <= 1'b0;
      end else begin
         ck_s1_r <= shift_clock_pin_sense;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         dt_s1_r <= serial_data_pin_sense;
         dt_s2_r <= dt_s1_r;
         div_r <= div_nxt;
         mck_r <= mck_nxt;
      end
   end

   // Bus slave: handshakes, register writes and read data.
   assign wr_en = aw_hold_r & w_hold_r & ~bvalid_r;
   assign wsel = usr_dec(awa_r);
   assign txb_wr = wr_en & wstb_r & (wsel == usr_pkg::SEL_TXB);
   assign pop = s_axi_arvalid & ~rvalid_r & (usr_dec(s_axi_araddr) == usr_pkg::SEL_RXB)
      & (cnt_r != 2'h0);
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      wstb_nxt = wstb_r;
      bvalid_nxt = bvalid_r & ~s_axi_bready;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r & ~s_axi_rready;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      rcv_nxt = rcv_r;
      txs_nxt = txs_r;
      baud_nxt = baud_r;
      ien_nxt = ien_r;
      continuous_receive_enable_clr = 1'b0;
      if (s_axi_awvalid & s_axi_awready) begin
         aw_hold_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         w_hold_nxt = 1'b1;
         wd_nxt = s_axi_wdata[7:0];
         wstb_nxt = s_axi_wstrb[0];
      end
      if (single_receive_enable_clr) begin
         rcv_nxt[usr_pkg::RC_SINGLE_RECEIVE_ENABLE] = 1'b0; // [R3]
      end
      if (wr_en) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wsel == usr_pkg::SEL_NONE) ? usr_pkg::RESP_SLVERR : usr_pkg::RESP_OKAY;
         if (wstb_r) begin
            case (wsel)
               usr_pkg::SEL_RCV: begin
                  rcv_nxt = wd_r & usr_pkg::RCV_WMASK;
                  continuous_receive_enable_clr = rcv_r[usr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE] & ~wd_r[usr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE]; // [R15]
               end
               usr_pkg::SEL_TX: txs_nxt = wd_r & usr_pkg::TX_WMASK;
               usr_pkg::SEL_BAUD: baud_nxt = wd_r;
               usr_pkg::SEL_IRQ: ien_nxt = wd_r[1:0];
               default: ;
            endcase
         end
      end
      if (s_axi_arvalid & s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = usr_pkg::RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         case (usr_dec(s_axi_araddr))
            usr_pkg::SEL_RCV: rdata_nxt[7:0] = rcv_r
               | {5'h00, head.framing_error_flag, overrun_error_flag_r, head.d9}; // [R14] [R16]
            usr_pkg::SEL_TX: rdata_nxt[7:0] = txs_r
               | {6'h00, tst_r == usr_pkg::TX_IDLE, 1'b0}; // [R20]
            usr_pkg::SEL_RXB: rdata_nxt[7:0] = head.data;
            usr_pkg::SEL_TXB: rdata_nxt[7:0] = 8'h00;
            usr_pkg::SEL_BAUD: rdata_nxt[7:0] = baud_r;
            usr_pkg::SEL_IRQ: rdata_nxt[7:0] = {4'h0, transmit_flag, receive_flag, ien_r};
            default: rresp_nxt = usr_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Bus slave registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awa_r <= '0;
         wd_r <= 8'h00;
         wstb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= usr_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= usr_pkg::RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         rcv_r <= usr_pkg::RCV_RST;
         txs_r <= usr_pkg::TX_RST;
         baud_r <= usr_pkg::BAUD_RST;
         ien_r <= 2'h0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         wstb_r <= wstb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         rcv_r <= rcv_nxt;
         txs_r <= txs_nxt;
         baud_r <= baud_nxt;
         ien_r <= ien_nxt;
      end
   end

   // Receive shifter, address filter, overrun and two entry FIFO.
   always_comb begin
      logic nine, done, full;
      usr_pkg::usr_rx_word_t w;
      nine = rcv_r[usr_pkg::RC_RX9];
      done = 1'b0;
      w = '0;
      rsr_nxt = rsr_r;
      rbits_nxt = rbits_r;
      overrun_error_flag_nxt = overrun_error_flag_r & ~continuous_receive_enable_clr; // [R15]
      single_receive_enable_clr = 1'b0;
      mem_nxt = mem_r;
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r ^ pop;
      cnt_nxt = cnt_r - {1'b0, pop}; // [R25]
      full = (cnt_r == usr_pkg::RX_DEPTH) & ~pop;
      if (!rx_on) begin
         rbits_nxt = 4'h0;
      end else if (ev.fall) begin
         rsr_nxt = {dt_s2_r, rsr_r[8:1]}; // [R2]
         rbits_nxt = rbits_r + 4'h1;
         if (rbits_nxt == usr_bits(nine)) begin // [R12]
            done = 1'b1;
            rbits_nxt = 4'h0;
         end
      end
      w.framing_error_flag = 1'b0;
      w.d9 = nine & rsr_nxt[8];
      w.data = nine ? rsr_nxt[7:0] : rsr_nxt[8:1];
      if (done) begin
         single_receive_enable_clr = master & ~rcv_r[usr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE]; // [R3] [R4]
         if (full) begin
            overrun_error_flag_nxt = 1'b1; // [R24]
         end else if (!(nine & rcv_r[usr_pkg::RC_ADDRESS_DETECT_ENABLE] & !w.d9)) begin // [R13]
            mem_nxt[wptr_r] = w; // [R23] [R10]
            wptr_nxt = ~wptr_r;
            cnt_nxt = cnt_nxt + 2'h1; // [R25]
         end
      end
      if (!rcv_r[usr_pkg::RC_SERIAL_PORT_ENABLE]) begin
         rbits_nxt = 4'h0; // [R11]
         overrun_error_flag_nxt = 1'b0;
         wptr_nxt = 1'b0;
         rptr_nxt = 1'b0;
         cnt_nxt = 2'h0;
      end
   end

   // Receive registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsr_r <= 9'h000;
         rbits_r <= 4'h0;
         overrun_error_flag_r <= 1'b0;
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         rsr_r <= rsr_nxt;
         rbits_r <= rbits_nxt;
         overrun_error_flag_r <= overrun_error_flag_nxt;
         mem_r <= mem_nxt;
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Transmit buffer and shifter; receive requests only pause it.
   always_comb begin
      logic load;
      load = 1'b0;
      tst_nxt = tst_r;
      tsr_nxt = tsr_r;
      tbits_nxt = tbits_r;
      dt_nxt = dt_r;
      txb_nxt = txb_r;
      txb_full_nxt = txb_full_r;
      tx_wake_nxt = tx_wake_r & sleep_mode;
      case (tst_r)
         usr_pkg::TX_IDLE: begin
            load = en & txs_r[usr_pkg::TC_TRANSMIT_ENABLE_BIT] & txb_full_r; // [R7]
         end
         usr_pkg::TX_SHIFT: begin
            if (tx_on & ev.rise & (tbits_r < usr_bits(txs_r[usr_pkg::TC_TX9]))) begin
               dt_nxt = tsr_r[0];
               tsr_nxt = {1'b0, tsr_r[8:1]};
               tbits_nxt = tbits_r + 4'h1;
            end else if (tx_on & ev.fall & (tbits_r == usr_bits(txs_r[usr_pkg::TC_TX9]))) begin
               tbits_nxt = tbits_r + 4'h1; // Hold the last bit past its falling edge.
            end else if (tbits_r > usr_bits(txs_r[usr_pkg::TC_TX9])) begin
               tst_nxt = usr_pkg::TX_IDLE;
               load = txb_full_r; // [R7]
               tx_wake_nxt = tx_wake_r | (sleep_mode & ~txb_full_r); // [R8]
            end
         end
         default: tst_nxt = usr_pkg::TX_IDLE;
      endcase
      if (load) begin
         tst_nxt = usr_pkg::TX_SHIFT;
         tsr_nxt = {txs_r[usr_pkg::TC_NINTH_TRANSMIT_BIT], txb_r}; // [R22]
         tbits_nxt = 4'h0;
         txb_full_nxt = 1'b0;
      end
      if (txb_wr) begin
         txb_nxt = wd_r;
         txb_full_nxt = 1'b1;
      end
      if (!en | !txs_r[usr_pkg::TC_TRANSMIT_ENABLE_BIT]) begin
         tst_nxt = usr_pkg::TX_IDLE; // [R11]
         tbits_nxt = 4'h0;
      end
      if (!rcv_r[usr_pkg::RC_SERIAL_PORT_ENABLE]) begin
         txb_full_nxt = 1'b0; // [R11]
         tx_wake_nxt = 1'b0;
      end
   end

   // Transmit registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tst_r <= usr_pkg::TX_IDLE;
         tsr_r <= 9'h000;
         tbits_r <= 4'h0;
         dt_r <= 1'b0;
         txb_r <= 8'h00;
         txb_full_r <= 1'b0;
         tx_wake_r <= 1'b0;
      end else begin
         tst_r <= tst_nxt;
         tsr_r <= tsr_nxt;
         tbits_r <= tbits_nxt;
         dt_r <= dt_nxt;
         txb_r <= txb_nxt;
         txb_full_r <= txb_full_nxt;
         tx_wake_r <= tx_wake_nxt;
      end
   end

   // Bus outputs.
   assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready = ~w_hold_r & ~bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // Pins, flags and wake.
   assign shift_clock_pin_drive = mck_r;
   assign shift_clock_pin_oe = en & master; // [R17] [R6]
   assign serial_data_pin_drive = dt_r;
   assign serial_data_pin_oe = tx_on & (tst_r == usr_pkg::TX_SHIFT); // [R21]
   assign receive_flag = cnt_r != 2'h0; // [R25]
   assign transmit_flag = ~txb_full_r & ~sleep_mode; // [R7]
   assign wake_request = (receive_flag & ien_r[usr_pkg::IE_RECEIVE_IRQ_ENABLE])
      | (tx_wake_r & ien_r[usr_pkg::IE_TRANSMIT_IRQ_ENABLE]); // [R8] [R10]

endmodule

// File: pkg/usr_pkg.sv
// Package with the register map, field positions and shared types of the serial port.
package usr_pkg;
   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] ADDR_RCV_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TX_CTRL = 8'h04;
   localparam logic [7:0] ADDR_RX_BUF = 8'h08;
   localparam logic [7:0] ADDR_TX_BUF = 8'h0C;
   localparam logic [7:0] ADDR_BAUD = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h14;
   // Receive control and status field positions.
   localparam int RC_SERIAL_PORT_ENABLE = 7;
   localparam int RC_RX9 = 6;
   localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
   localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int RC_ADDRESS_DETECT_ENABLE = 3;
   // Transmit control and status field positions.
   localparam int TC_CLOCK_SOURCE_SELECT = 7;
   localparam int TC_TX9 = 6;
   localparam int TC_TRANSMIT_ENABLE_BIT = 5;
   localparam int TC_SYNC = 4;
   localparam int TC_NINTH_TRANSMIT_BIT = 0;
   // Interrupt enable field positions.
   localparam int IE_RECEIVE_IRQ_ENABLE = 0;
   localparam int IE_TRANSMIT_IRQ_ENABLE = 1;
   // Writable bit masks and reset values.
   localparam logic [7:0] RCV_WMASK = 8'hF8;
   localparam logic [7:0] TX_WMASK = 8'hF5;
   localparam logic [7:0] RCV_RST = 8'h00;
   localparam logic [7:0] TX_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   // Frame lengths in bits.
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_9 = 4'h9;
   // Receive FIFO depth in words.
   localparam logic [1:0] RX_DEPTH = 2'h2;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register selector produced by the address decoder.
   typedef enum logic [2:0] {
      SEL_RCV, SEL_TX, SEL_RXB, SEL_TXB, SEL_BAUD, SEL_IRQ, SEL_NONE
   } usr_sel_t;
   // Transmit shifter states.
   typedef enum logic {TX_IDLE, TX_SHIFT} usr_tx_state_t;
   // One received word with its status bits.
   typedef struct packed {
      logic framing_error_flag;
      logic d9;
      logic [7:0] data;
   } usr_rx_word_t;
   // Shift clock edge events.
   typedef struct packed {
      logic rise;
      logic fall;
   } usr_edge_t;
endpackage

// File: testbench/usr_sync_port_checker.sv
// Concurrent checks on the bus and pin ports of the serial port.
`timescale 1ns/1ps
module usr_sync_port_checker #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels.
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins.
   input wire logic shift_clock_pin_sense,
   input wire logic shift_clock_pin_drive,
   input wire logic shift_clock_pin_oe,
   input wire logic serial_data_pin_sense,
   input wire logic serial_data_pin_drive,
   input wire logic serial_data_pin_oe,
   // Sleep and flags.
   input wire logic sleep_mode,
   input wire logic receive_flag,
   input wire logic transmit_flag,
   input wire logic wake_request
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Handshake steps that start a bus answer.
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response not on time");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data not on time");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   a_unmapped_err: assert property (rd_taken ##0 s_axi_araddr[7:0] >= 8'h18
      |=> s_axi_rresp == usr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_sleep_txflag: assert property (sleep_mode |-> !transmit_flag)
      else $error("transmit flag set during sleep");
   a_wake_cause: assert property (wake_request && !receive_flag |-> sleep_mode || $past(sleep_mode))
      else $error("wake without a cause");
   a_clk_master: assert property ($rose(shift_clock_pin_drive) |-> shift_clock_pin_oe)
      else $error("clock pulse without clock drive");
   a_rx_flag_pop: assert property ($fell(receive_flag)
      |-> s_axi_rvalid || $past(s_axi_rvalid) || s_axi_bvalid || $past(s_axi_bvalid))
      else $error("receive flag dropped without a bus access");
endmodule
bind usr_sync_port usr_sync_port_checker #(.ADDR_W(ADDR_W)) checker_inst (.*);

// File: testbench/usr_remote_model.sv
// Remote synchronous party: clock master or clock slave on the two serial lines.
`timescale 1ns/1ps
module usr_remote_model (
   // Levels seen on the lines.
   input wire logic ck_wire,
   input wire logic dt_wire,
   // Drive of the clock line.
   output logic ck_out,
   output logic ck_oe,
   // Drive of the data line.
   output logic dt_out,
   output logic dt_oe
);
   logic [8:0] word = 9'h000;
   logic [8:0] cap = 9'h000;
   int idx = 0;
   // Lines start released.
   initial begin
      ck_out = 1'b0;
      ck_oe = 1'b0;
      dt_out = 1'b0;
      dt_oe = 1'b0;
   end
   // As clock slave, present the next bit after each rising edge, low bit first.
   always @(posedge ck_wire) begin
      if (dt_oe && !ck_oe) begin
         dt_out <= word[idx];
         idx <= idx + 1;
      end
   end
   // Capture the data line at each falling edge, last bit ends up on top.
   always @(negedge ck_wire) cap <= {dt_wire, cap[8:1]};
   // As clock master, set data mid low phase so it is settled over the fall.
   task master_word(input logic [8:0] w, input int n, input logic drive);
      #30; // Keep every line change clear of the device's clock edges.
      ck_oe = 1'b1;
      dt_oe = drive;
      for (int i = 0; i < n; i++) begin
         #200 dt_out = w[i];
         #200 ck_out = 1'b1;
         #400 ck_out = 1'b0;
      end
      #200 dt_oe = 1'b0;
   endtask
   // Prepare a word to send under the device's clock.
   task serve(input logic [8:0] w);
      word = w;
      idx = 0;
      dt_oe = 1'b1;
   endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the synchronous serial port.
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] RC = usr_pkg::ADDR_RCV_CTRL;
   localparam logic [7:0] TC = usr_pkg::ADDR_TX_CTRL;
   localparam logic [7:0] RB = usr_pkg::ADDR_RX_BUF;
   localparam logic [7:0] TB = usr_pkg::ADDR_TX_BUF;
   localparam logic [7:0] IQ = usr_pkg::ADDR_IRQ_CTRL;
   logic aclk;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, sleep_mode = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic shift_clock_pin_drive, shift_clock_pin_oe, serial_data_pin_drive, serial_data_pin_oe;
   logic receive_flag, transmit_flag, wake_request;
   logic p_ck, p_ck_oe, p_dt, p_dt_oe, shift_clock_pin_sense, serial_data_pin_sense;
   logic dt_float = 1'b0;
   logic [31:0] rv;
   int fail_count = 0;
   int checks_done = 0;
   // Resolve both lines; a released data line shows a changing pattern.
   assign shift_clock_pin_sense = shift_clock_pin_oe ? shift_clock_pin_drive : (p_ck_oe & p_ck);
   assign serial_data_pin_sense = serial_data_pin_oe ? serial_data_pin_drive :
                                  (p_dt_oe ? p_dt : dt_float);
   // Clock and floating pattern.
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) dt_float <= ~dt_float;
   usr_sync_port usr_sync_port_inst (.*);
   usr_remote_model usr_remote_model_inst (.ck_wire(shift_clock_pin_sense),
      .dt_wire(serial_data_pin_sense), .ck_out(p_ck), .ck_oe(p_ck_oe), .dt_out(p_dt),
      .dt_oe(p_dt_oe));
   // Compare and count.
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
         fail_count++;
      end
   endtask
   // Bus write: both channels offered together, held until each is taken.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Bus read into rv.
   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask
   task mw(input logic [8:0] w, input int n, input logic d);
      usr_remote_model_inst.master_word(w, n, d);
      repeat (6) @(posedge aclk);
   endtask
   task sc_regs;
      rc(RC, 32'h0000_0000);
      rc(TC, 32'h0000_0002);
      rd(8'h18);
      chk(resp, usr_pkg::RESP_SLVERR);
      wr(usr_pkg::ADDR_BAUD, 8'h03);
      wr(TC, 8'h04);
      rc(TC, 32'h0000_0006);
   endtask
   task sc_mtx;
      wr(RC, 8'h80);
      wr(TC, 8'hF1);
      wr(TB, 8'h3C);
      rd(TC);
      chk(rv[1], 1'b0);
      do begin
         rd(TC);
      end while (rv[1] !== 1'b1);
      chk(usr_remote_model_inst.cap, 9'h13C);
      chk(shift_clock_pin_oe, 1'b1);
   endtask
   task sc_mrx;
      wr(TC, 8'h90);
      usr_remote_model_inst.serve(9'h096);
      wr(RC, 8'hA0);
      while (receive_flag !== 1'b1) begin
         @(posedge aclk);
      end
      rd(RC);
      chk(rv & 32'h0000_00F8, 32'h0000_0080);
      rc(RB, 32'h0000_0096);
      chk(receive_flag, 1'b0);
      usr_remote_model_inst.dt_oe = 1'b0;
      wr(RC, 8'h00);
      chk(shift_clock_pin_oe, 1'b0);
   endtask
   task sc_srx;
      wr(TC, 8'h10);
      wr(IQ, 8'h01);
      wr(RC, 8'h90);
      sleep_mode <= 1'b1;
      mw(9'h011, 8, 1'b1);
      chk(wake_request, 1'b1);
      sleep_mode <= 1'b0;
      mw(9'h022, 8, 1'b1);
      mw(9'h033, 8, 1'b1);
      rd(RC);
      chk(rv[1], 1'b1);
      rc(RB, 32'h0000_0011);
      rc(RB, 32'h0000_0022);
      mw(9'h044, 8, 1'b1);
      chk(receive_flag, 1'b0);
      wr(RC, 8'h80);
      rd(RC);
      chk(rv[1], 1'b0);
      wr(RC, 8'hA0);
      mw(9'h055, 8, 1'b1);
      chk(receive_flag, 1'b0);
   endtask
   task sc_addr;
      wr(IQ, 8'h00);
      wr(RC, 8'hD8);
      mw(9'h0A5, 9, 1'b1);
      mw(9'h15A, 9, 1'b1);
      rd(RC);
      chk(rv[0], 1'b1);
      rc(RB, 32'h0000_005A);
      chk(receive_flag, 1'b0);
   endtask
   task sc_stx;
      wr(RC, 8'h80);
      wr(TC, 8'h30);
      wr(IQ, 8'h02);
      sleep_mode <= 1'b1;
      wr(TB, 8'hA1);
      wr(TB, 8'hB2);
      chk(transmit_flag, 1'b0);
      mw(9'h000, 8, 1'b0);
      chk(usr_remote_model_inst.cap[8:1], 8'hA1);
      mw(9'h000, 8, 1'b0);
      chk(usr_remote_model_inst.cap[8:1], 8'hB2);
      chk(wake_request, 1'b1);
      sleep_mode <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(transmit_flag, 1'b1);
      chk(wake_request, 1'b0);
   endtask
   // Verdict and end of run.
   task wrap_up;
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Main sequence after reset.
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      sc_regs;
      sc_mtx;
      sc_mrx;
      sc_srx;
      sc_addr;
      sc_stx;
      wrap_up;
   end
   // Watchdog well beyond the expected run.
   initial begin
      #3_000_000;
      fail_count++;
      wrap_up;
   end
endmodule
